/* File: src/ctw_defs.vh */
// constants for the can transceiver mode and wake control block
// assumes a 10 mhz hclk; plain include by bare name
`ifndef CTW_DEFS_VH
`define CTW_DEFS_VH

// register byte offsets
`define CTW_OFF_CTRL 12'h000
`define CTW_OFF_STATUS 12'h004
`define CTW_OFF_WAKE_FILT 12'h008
`define CTW_OFF_WAKE_WIN 12'h00c
`define CTW_OFF_DOM_TO 12'h010
`define CTW_OFF_EXIT_DLY 12'h014

// ctrl fields
`define CTW_CTRL_WAKE_CLR 0

// status fields
`define CTW_ST_MODE 0
`define CTW_ST_WAKE 1
`define CTW_ST_THERM 2
`define CTW_ST_DOMTO 3
`define CTW_ST_SWOFF 4
`define CTW_ST_EXITING 5
`define CTW_ST_TXD_ARM 6
`define CTW_ST_WSTATE 8

// timing defaults in cycles of the internal 10 mhz clock
`define CTW_WAKE_FILT_CYC 32'd5
`define CTW_WAKE_WIN_CYC 32'd10000
`define CTW_DOM_TO_CYC 32'd10000
`define CTW_EXIT_DLY_CYC 32'd200

// wake detector states
`define CTW_W_IDLE 3'd0
`define CTW_W_DOM1 3'd1
`define CTW_W_REC 3'd2
`define CTW_W_DOM2 3'd3
`define CTW_W_DONE 3'd4

`endif

/* File: src/ctw_top.v */
// mode, wake-up and protection logic of a high-speed can transceiver
// assumes all pins synchronous to hclk; supply and thermal flags are digital levels
`timescale 1ns/1ps
`include "ctw_defs.vh"

// Operation
// - standby-select low gives normal mode, high gives standby mode.
// - normal mode: receive output low on dominant bus, high on recessive.
// - normal mode: transmit input low drives dominant, high leaves recessive.
// - standby disables normal transmitter and receiver; wake receiver monitors bus.
// - standby: low-power receiver keeps watching the bus for wake activity.
// - standby: receive output high until wake verified, then follows the bus.
// - wake needs dominant, recessive, dominant phases each at least filter time.
// - pattern not complete within wake window resets wake logic.
// - overtemperature switches off only the transmitter.
// - thermal off clears once overtemperature gone and transmit input high.
// - a falling transmit edge starts the dominant-timeout timer.
// - transmit low beyond timeout disables transmitter, bus recessive.
// - a rising transmit edge resets the timer and re-enables sending.
// - main supply standby undervoltage forces standby mode.
// - interface supply undervoltage forces standby mode.
// - switch-off undervoltage disengages the bus until supply recovers.
// - after recovery no dominant until transmit input first returns high.
// - undervoltage recovery takes the same time as standby-to-normal exit.
// - unconnected transmit or standby-select input reads high.
// - wake detection runs from the interface supply without main supply.
module ctw_top #(
  parameter [31:0] WAKE_FILT_CYC = `CTW_WAKE_FILT_CYC,
  parameter [31:0] WAKE_WIN_CYC = `CTW_WAKE_WIN_CYC,
  parameter [31:0] DOM_TO_CYC = `CTW_DOM_TO_CYC,
  parameter [31:0] EXIT_DLY_CYC = `CTW_EXIT_DLY_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire txd,
  input wire txd_connected,
  input wire stby_sel,
  input wire stby_sel_connected,
  input wire bus_dominant,
  input wire wake_rx_dominant,
  input wire overtemp,
  input wire main_uv_standby,
  input wire main_uv_switchoff,
  input wire interface_supply_present,
  input wire interface_supply_uv,
  output reg rxd,
  output reg bus_drive_dominant,
  output reg bus_engaged,
  output reg normal_rx_enable,
  output reg wake_rx_enable,
  output reg wake_detected
);

  // unconnected pins read high through the pull-ups
  wire txd_in = txd | ~txd_connected;
  wire stb_in = stby_sel | ~stby_sel_connected;

  reg [31:0] wake_filt_cfg;
  reg [31:0] wake_win_cfg;
  reg [31:0] dom_to_cfg;
  reg [31:0] exit_dly_cfg;

  // ---------------- ahb-lite slave ----------------
  reg ph_wr;
  reg ph_rd;
  reg [11:0] ph_addr;
  reg wake_clr_req;
  reg [31:0] status_word;
  wire ahb_go = hsel & hready & htrans[1];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      ph_wr <= ahb_go & hwrite;
      ph_rd <= ahb_go & ~hwrite;
      if (ahb_go)
        ph_addr <= haddr[11:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data registered in the address phase so hrdata comes from a flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ahb_go & ~hwrite) begin
      case (haddr[11:0])
        `CTW_OFF_STATUS: hrdata <= status_word;
        `CTW_OFF_WAKE_FILT: hrdata <= wake_filt_cfg;
        `CTW_OFF_WAKE_WIN: hrdata <= wake_win_cfg;
        `CTW_OFF_DOM_TO: hrdata <= dom_to_cfg;
        `CTW_OFF_EXIT_DLY: hrdata <= exit_dly_cfg;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_filt_cfg <= WAKE_FILT_CYC;
      wake_win_cfg <= WAKE_WIN_CYC;
      dom_to_cfg <= DOM_TO_CYC;
      exit_dly_cfg <= EXIT_DLY_CYC;
      wake_clr_req <= 1'b0;
    end else begin
      wake_clr_req <= 1'b0;
      if (ph_wr) begin
        case (ph_addr)
          `CTW_OFF_CTRL: wake_clr_req <= hwdata[`CTW_CTRL_WAKE_CLR];
          // zero counts would make phases meaningless, so clamp filter, window and timeout to one
          `CTW_OFF_WAKE_FILT: wake_filt_cfg <= (hwdata == 32'h0) ? 32'h1 : hwdata;
          `CTW_OFF_WAKE_WIN: wake_win_cfg <= (hwdata == 32'h0) ? 32'h1 : hwdata;
          `CTW_OFF_DOM_TO: dom_to_cfg <= (hwdata == 32'h0) ? 32'h1 : hwdata;
          `CTW_OFF_EXIT_DLY: exit_dly_cfg <= hwdata;
          default: wake_clr_req <= 1'b0;
        endcase
      end
    end
  end

  // ---------------- supply and mode ----------------
  reg txd_q;
  reg swoff;
  reg armed;
  reg exiting;
  reg [31:0] exit_cnt;
  reg normal_mode;
  wire main_ok = ~main_uv_standby & ~main_uv_switchoff;
  wire force_stby = main_uv_standby | interface_supply_uv;
  wire want_normal = ~stb_in & ~force_stby & ~swoff;
  wire txd_fall = txd_q & ~txd_in;
  wire txd_rise = ~txd_q & txd_in;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_q <= 1'b1;
      swoff <= 1'b0;
      armed <= 1'b0;
    end else begin
      txd_q <= txd_in;
      if (main_uv_switchoff)
        swoff <= 1'b1;
      else if (main_ok)
        swoff <= 1'b0;
      // any forced standby or disengage needs txd to go high before dominant
      if (main_uv_switchoff | force_stby)
        armed <= 1'b0;
      else if (txd_in)
        armed <= 1'b1;
    end
  end

  // standby to normal and undervoltage recovery share one exit delay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      normal_mode <= 1'b0;
      exiting <= 1'b0;
      exit_cnt <= 32'h0;
    end else if (!want_normal) begin
      normal_mode <= 1'b0;
      exiting <= 1'b0;
      exit_cnt <= 32'h0;
    end else if (!normal_mode) begin
      if (!exiting) begin
        exiting <= 1'b1;
        exit_cnt <= 32'h0;
      end else if (exit_cnt + 32'h1 >= exit_dly_cfg) begin
        normal_mode <= 1'b1;
        exiting <= 1'b0;
      end else begin
        exit_cnt <= exit_cnt + 32'h1;
      end
    end
  end

  // ---------------- dominant timeout and thermal ----------------
  reg dom_to;
  reg [31:0] dom_cnt;
  reg therm_off;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dom_to <= 1'b0;
      dom_cnt <= 32'h0;
    end else if (txd_rise) begin
      dom_to <= 1'b0;
      dom_cnt <= 32'h0;
    end else if (txd_fall) begin
      dom_cnt <= 32'h1;
    end else if (!txd_in && !dom_to && dom_cnt != 32'h0) begin
      if (dom_cnt >= dom_to_cfg)
        dom_to <= 1'b1;
      else
        dom_cnt <= dom_cnt + 32'h1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      therm_off <= 1'b0;
    else if (overtemp)
      therm_off <= 1'b1;
    else if (txd_in)
      therm_off <= 1'b0;
  end

  // ---------------- wake detector ----------------
  reg [2:0] wstate;
  reg [31:0] phase_cnt;
  reg [31:0] win_cnt;
  // runs from the interface supply as well, so main supply loss does not stop it
  wire wake_pwr = main_ok | interface_supply_present;
  wire wake_run = ~normal_mode & wake_pwr;
  wire phase_ok = (phase_cnt + 32'h1) >= wake_filt_cfg;
  wire win_out = (win_cnt >= wake_win_cfg) & (wstate != `CTW_W_IDLE);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wstate <= `CTW_W_IDLE;
      phase_cnt <= 32'h0;
      win_cnt <= 32'h0;
      wake_detected <= 1'b0;
    end else if (!wake_run) begin
      wstate <= `CTW_W_IDLE;
      phase_cnt <= 32'h0;
      win_cnt <= 32'h0;
      wake_detected <= 1'b0;
    end else if (win_out && wstate != `CTW_W_DONE) begin
      wstate <= `CTW_W_IDLE;
      phase_cnt <= 32'h0;
      win_cnt <= 32'h0;
    end else begin
      if (wstate != `CTW_W_IDLE && wstate != `CTW_W_DONE)
        win_cnt <= win_cnt + 32'h1;
      case (wstate)
        `CTW_W_IDLE: begin
          phase_cnt <= 32'h0;
          win_cnt <= 32'h0;
          if (wake_rx_dominant)
            wstate <= `CTW_W_DOM1;
        end
        `CTW_W_DOM1: begin
          if (wake_rx_dominant) begin
            phase_cnt <= phase_cnt + 32'h1;
          end else if (phase_ok) begin
            wstate <= `CTW_W_REC;
            phase_cnt <= 32'h0;
          end else begin
            wstate <= `CTW_W_IDLE;
          end
        end
        `CTW_W_REC: begin
          if (!wake_rx_dominant) begin
            phase_cnt <= phase_cnt + 32'h1;
          end else if (phase_ok) begin
            wstate <= `CTW_W_DOM2;
            phase_cnt <= 32'h0;
          end else begin
            wstate <= `CTW_W_DOM1;
            phase_cnt <= 32'h0;
          end
        end
        `CTW_W_DOM2: begin
          if (!wake_rx_dominant) begin
            wstate <= `CTW_W_REC;
            phase_cnt <= 32'h0;
          end else if (phase_ok) begin
            wstate <= `CTW_W_DONE;
            wake_detected <= 1'b1;
          end else begin
            phase_cnt <= phase_cnt + 32'h1;
          end
        end
        `CTW_W_DONE: begin
          // stays verified until normal mode, loss of wake supply or software clear
          if (wake_clr_req) begin
            wstate <= `CTW_W_IDLE;
            wake_detected <= 1'b0;
          end
        end
        default: wstate <= `CTW_W_IDLE;
      endcase
    end
  end

  // ---------------- pin outputs ----------------
  wire tx_ok = normal_mode & ~therm_off & ~dom_to & armed & ~swoff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd <= 1'b1;
      bus_drive_dominant <= 1'b0;
      bus_engaged <= 1'b0;
      normal_rx_enable <= 1'b0;
      wake_rx_enable <= 1'b0;
    end else begin
      if (normal_mode)
        rxd <= ~bus_dominant;
      else if (wake_detected)
        rxd <= ~wake_rx_dominant;
      else
        rxd <= 1'b1;
      bus_drive_dominant <= tx_ok & ~txd_in;
      bus_engaged <= ~swoff;
      normal_rx_enable <= normal_mode;
      wake_rx_enable <= wake_run;
    end
  end

  always @* begin
    status_word = 32'h00000000;
    status_word[`CTW_ST_MODE] = normal_mode;
    status_word[`CTW_ST_WAKE] = wake_detected;
    status_word[`CTW_ST_THERM] = therm_off;
    status_word[`CTW_ST_DOMTO] = dom_to;
    status_word[`CTW_ST_SWOFF] = swoff;
    status_word[`CTW_ST_EXITING] = exiting;
    status_word[`CTW_ST_TXD_ARM] = armed;
    status_word[`CTW_ST_WSTATE+2:`CTW_ST_WSTATE] = wstate;
  end

endmodule

/* File: sim/ctw_checker.sv */
// port assertions for the can transceiver mode and wake control block
// assumes the single hclk domain and active-low async hresetn
`timescale 1ns/1ps
module ctw_checker #(
  parameter [31:0] DOM_TO_CYC = 32'd20
) (
  input wire hclk,
  input wire hresetn,
  input wire txd,
  input wire stby_sel,
  input wire stby_sel_connected,
  input wire bus_dominant,
  input wire wake_rx_dominant,
  input wire overtemp,
  input wire main_uv_standby,
  input wire main_uv_switchoff,
  input wire hreadyout,
  input wire hresp,
  input wire rxd,
  input wire bus_drive_dominant,
  input wire bus_engaged,
  input wire normal_rx_enable,
  input wire wake_detected
);
  reg [31:0] low_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // counts sampled low cycles of txd; saturates so a stuck pin cannot wrap
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt <= 32'h0;
    else if (txd) low_cnt <= 32'h0;
    else if (low_cnt != 32'hffffffff) low_cnt <= low_cnt + 32'h1;
  end
  chk_rx_normal: assert property (normal_rx_enable && $past(normal_rx_enable)
    |-> rxd == !$past(bus_dominant)) else $error("rxd does not mirror bus in normal mode");
  chk_rx_idle: assert property (!normal_rx_enable && !wake_detected
    && $past(!normal_rx_enable && !wake_detected) |-> rxd) else $error("rxd low before wake");
  chk_wake_follow: assert property (wake_detected && $past(wake_detected)
    && !normal_rx_enable && $past(!normal_rx_enable) |-> rxd == !$past(wake_rx_dominant))
    else $error("rxd does not follow bus after wake");
  // thermal, switch-off and mode flags pass one flop before the pin flops, hence depth 2
  chk_tx_cause: assert property (bus_drive_dominant |-> $past(!txd)
    && $past(!overtemp, 2)
    && !$past(main_uv_switchoff, 2)) else $error("dominant without cause");
  chk_mode_select: assert property (normal_rx_enable
    |-> $past(stby_sel_connected && !stby_sel && !main_uv_standby, 2))
    else $error("bad normal mode");
  chk_standby_quiet: assert property (!normal_rx_enable && $past(!normal_rx_enable)
    |-> !bus_drive_dominant) else $error("transmitter active in standby");
  chk_dom_timeout: assert property (low_cnt > DOM_TO_CYC + 32'd2
    |-> !bus_drive_dominant) else $error("dominant timeout missed");
  chk_swoff_off: assert property (main_uv_switchoff [*3]
    |-> !bus_engaged && !bus_drive_dominant) else $error("still engaged at switch-off");
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  cover property ($rose(wake_detected));
  cover property ($fell(bus_drive_dominant) && !txd);
  cover property ($rose(normal_rx_enable));
endmodule

/* File: sim/ctw_ctrl_model.sv */
// protocol controller model: sends a start bit, a byte msb first, a stop bit
// assumes the bench pulses start for one cycle while busy is low
`timescale 1ns/1ps
module ctw_ctrl_model #(
  parameter int BIT_CYC = 2
) (
  input wire hclk,
  input wire start,
  input wire [7:0] data,
  output logic txd,
  output logic busy
);
  int cnt;
  logic [9:0] sh;
  initial begin
    txd = 1'b1;
    busy = 1'b0;
    cnt = 0;
    sh = '1;
  end
  // short bit time keeps nine low bits under the dominant timeout
  always @(posedge hclk) begin
    if (start && !busy) begin
      sh <= {1'b0, data, 1'b1};
      cnt <= 0;
      busy <= 1'b1;
    end else if (busy) begin
      txd <= sh[9];
      cnt <= cnt + 1;
      if (cnt % BIT_CYC == BIT_CYC - 1) sh <= {sh[8:0], 1'b1};
      if (cnt == 10 * BIT_CYC - 1) busy <= 1'b0; // stop bit leaves txd high
    end
  end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for ctw_top with a controller model on txd
// assumes zero-wait ahb slave and shortened timer parameters
`timescale 1ns/1ps
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic hreadyout, hresp, rxd, drv, eng, nrm, wake, mtxd, busy, txd_d = 1'b1;
  logic stby = 1'b1, stby_con = 1'b1, wdom = 1'b0, ot = 1'b0, uvs = 1'b0, uvo = 1'b0;
  logic iouv = 1'b0, flow = 1'b0, start = 1'b0, chk_on = 1'b0;
  logic tcon = 1'b1, iop = 1'b1, wren;
  logic [2:0] hsize = 3'b000;
  logic [7:0] data = 8'h00;
  int fail_count = 0, tests_run = 0;
  wire txd = flow ? 1'b0 : mtxd;
  always #50 hclk = ~hclk;
  ctw_ctrl_model #(.BIT_CYC(2)) i_ctw_ctrl_model (.hclk(hclk), .start(start), .data(data),
    .txd(mtxd), .busy(busy));
  ctw_top #(.WAKE_FILT_CYC(3), .WAKE_WIN_CYC(40), .DOM_TO_CYC(20), .EXIT_DLY_CYC(4)) i_ctw_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .txd_connected(tcon), .stby_sel(stby),
    .stby_sel_connected(stby_con), .bus_dominant(drv), .wake_rx_dominant(wdom),
    .overtemp(ot), .main_uv_standby(uvs), .main_uv_switchoff(uvo),
    .interface_supply_present(iop), .interface_supply_uv(iouv), .rxd(rxd),
    .bus_drive_dominant(drv), .bus_engaged(eng), .normal_rx_enable(nrm),
    .wake_rx_enable(wren), .wake_detected(wake));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single transfer; entered right after a rising edge
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    hsize <= 3'b010;
    cyc(1);
    while (!hreadyout) cyc(1);
    htrans <= 2'b00; hwdata <= wd;
    cyc(1);
    while (!hreadyout) cyc(1);
    rd = hrdata;
  endtask
  task automatic wpat(input int a, input int b, input int c, input logic exp);
    wdom <= 1'b1; cyc(a); wdom <= 1'b0; cyc(b); wdom <= 1'b1; cyc(c);
    check(wake, exp);
    check(rxd, !exp);
    // long tail lets the wake window run out so a half pattern cannot leak into the next call
    wdom <= 1'b0; cyc(45);
  endtask
  // txd pulse high then low again, re-arming the transmitter
  task automatic rearm;
    flow <= 1'b0; cyc(2); flow <= 1'b1; cyc(3);
  endtask
  always @(posedge hclk) begin
    txd_d <= txd;
    if (chk_on) check(drv, !txd_d);
  end
  initial begin
    #(100 * 20000);
    fail_count++;
    print_verdict();
  end
  initial begin
    logic [31:0] rd;
    void'($urandom(13575));
    cyc(12); hresetn <= 1'b1; cyc(1);
    check(rxd, 1);
    ahb(32'h8, 1'b0, 0, rd); check(rd, 3);
    ahb(32'h20, 1'b0, 0, rd); check(rd, 0);
    uvs <= 1'b1;
    wpat(4, 4, 6, 1'b1);
    check(wren, 1);
    ahb(32'h0, 1'b1, 1, rd); cyc(2); check(wake, 0);
    iop <= 1'b0; cyc(2); check(wren, 0);
    uvs <= 1'b0; iop <= 1'b1; cyc(2); check(wren, 1);
    wpat(2, 4, 6, 1'b0);
    wpat(4, 45, 6, 1'b0);
    stby <= 1'b0; cyc(2); check(nrm, 0); cyc(6); check(nrm, 1);
    check(wren, 0);
    chk_on <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      data <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      start <= 1'b1; cyc(1); start <= 1'b0; cyc(2);
      while (busy) cyc(1);
    end
    chk_on <= 1'b0;
    flow <= 1'b1; cyc(2); check(drv, 1); cyc(22); check(drv, 0);
    rearm(); check(drv, 1);
    ot <= 1'b1; rearm(); check(drv, 0); check(nrm, 1);
    ot <= 1'b0; cyc(3); check(drv, 0); rearm(); check(drv, 1);
    for (int k = 0; k < 2; k++) begin
      rearm();
      if (k == 0) uvs <= 1'b1; else iouv <= 1'b1;
      cyc(3); check(nrm, 0); check(drv, 0);
      uvs <= 1'b0; iouv <= 1'b0; cyc(8); check(nrm, 1); check(drv, 0);
      rearm(); check(drv, 1);
    end
    uvo <= 1'b1; cyc(3); check(eng, 0);
    uvo <= 1'b0; cyc(8); check(eng, 1); check(drv, 0);
    rearm(); check(drv, 1);
    tcon <= 1'b0; cyc(2); check(drv, 0);
    flow <= 1'b0; stby_con <= 1'b0; cyc(3); check(nrm, 0);
    print_verdict();
  end
endmodule
bind ctw_top ctw_checker #(.DOM_TO_CYC(DOM_TO_CYC)) i_ctw_checker (.hclk(hclk),
  .hresetn(hresetn), .txd(txd), .stby_sel(stby_sel), .stby_sel_connected(stby_sel_connected),
  .bus_dominant(bus_dominant), .wake_rx_dominant(wake_rx_dominant), .overtemp(overtemp),
  .main_uv_standby(main_uv_standby), .main_uv_switchoff(main_uv_switchoff),
  .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .bus_drive_dominant(bus_drive_dominant),
  .bus_engaged(bus_engaged), .normal_rx_enable(normal_rx_enable),
  .wake_detected(wake_detected));
